// ===== design/tkf_cmd_fields.v
/*
 * touch key host command fields: decodes parameter bytes of the sleep,
 * key enable and output commands, builds touch, fault and probe answers,
 * applies group lockout, and runs the sleep interval timer.
 * assumes byte framing, checksum and parity checks are done outside and
 * presented as one-cycle command strobes with their parameter bytes.
 * limitation: a wake from interval sleep by an address lasts only while traffic is seen.
 */
// Functional notes
// - answer with one-byte result codes
// - fault byte: bit7 touched, bits6-3 zero
// - summary ORs faults; per-key gives one key
// - fault bits: calibrating, max, min
// - touch bitmap bit n-1 is key n
// - enable bit one enables, zero disables
// - free-run bit suspends sleep while detecting
// - factor zero or 1a-3e disables sleep
// - factor 01-19 sleeps factor times 20ms
// - factor 3f deep sleep, bus wakes
// - asleep: no address ack, but wakes
// - output byte bits 0-4 drive outputs
// - mode zero: first key locks group
// - mode one: strongest key wins group
// - membership bit x-1 means group x
// - probe codes per key diagnostic state
// - enable change recalibrates enabled keys
`timescale 1ns/100ps
`include "tkf_regs.vh"

module tkf_cmd_fields #(
	parameter SLEEP_STEP_CYC = `TKF_SLEEP_STEP_MS * (`TKF_CLK_HZ / 1000),
	parameter LEVEL_W        = 8
) (
	input  wire                 clk,
	input  wire                 reset,
	// command strobes from the framer
	input  wire                 cmdValid,
	input  wire [7:0]           cmdOpcode,
	input  wire [7:0]           cmdLength,
	input  wire [7:0]           cmdParam,
	input  wire                 cmdChecksumOk,
	input  wire                 cmdParityOk,
	input  wire                 cmdKnown,
	// group configuration command (mode byte plus membership)
	input  wire                 grpValid,
	input  wire [7:0]           grpStyle,
	input  wire [63:0]          grpMembers,
	// sensing core state
	input  wire [7:0]           rawTouch,
	input  wire [7:0]           keyCalibrating,
	input  wire [7:0]           keyMaxCount,
	input  wire [7:0]           keyMinCount,
	input  wire [8*LEVEL_W-1:0] keyLevel,
	input  wire [7:0]           keyFilterPos,
	input  wire [7:0]           keyFilterTouch,
	input  wire [7:0]           keyFilterRelease,
	input  wire [2:0]           queryKey,
	// bus activity seen by the slave front end
	input  wire                 busActivity,
	input  wire                 addrMatch,
	output reg  [7:0]           resultCode,
	output reg                  resultValid,
	output reg  [7:0]           touchBitmap,
	output reg  [7:0]           summaryFaultByte,
	output reg  [7:0]           keyFaultByte,
	output reg  [7:0]           keyProbeCode,
	output reg  [7:0]           keyEnabled,
	output reg                  recalStart,
	output reg  [7:0]           recalKeys,
	output reg  [4:0]           outputPinLevels,
	output reg                  lowPowerActive,
	output reg                  deepSleep,
	output reg                  sleepTick,
	output wire                 addrAck
);

	// step compare held at 32 bits; the default step fits easily
	localparam [31:0] STEP_CYC = SLEEP_STEP_CYC;

	// ==========================================================
	// registers
	reg        fwSeen_q;
	reg [7:0]  grpStyle_q;
	reg [63:0] grpMembers_q;
	reg        freeRun_q;
	reg [5:0]  sleepFactor_q;
	reg [31:0] stepCnt_q;
	reg [4:0]  stepNum_q;
	reg [7:0]  lockOwner_q;

	// ==========================================================
	// helpers
	// selector zero means every key; 9 to 15 are refused before use
	function [7:0] keySelMask;
		input [3:0] sel;
		begin
			if (sel == 4'h0)
				keySelMask = 8'hff;
			else
				keySelMask = 8'h01 << (sel - 4'h1);
		end
	endfunction

	// fault field of one key: min, max, calibrating
	function [2:0] faultOf;
		input [2:0] k;
		begin
			faultOf = {keyMinCount[k], keyMaxCount[k], keyCalibrating[k]};
		end
	endfunction

	// ==========================================================
	// command parameter check
	// framing faults outrank the init guard, which outranks decoding;
	// a refused command leaves every setting untouched
	reg [7:0] rcNext;
	always @* begin
		rcNext = `TKF_RC_OK;
		if (!cmdParityOk)
			rcNext = `TKF_RC_PARITY;
		else if (!cmdChecksumOk)
			rcNext = `TKF_RC_CHECKSUM;
		else if (!fwSeen_q && cmdOpcode != `TKF_OP_FWINFO)
			rcNext = `TKF_RC_INIT;
		else if (!cmdKnown)
			rcNext = `TKF_RC_BAD_CMD;
		else if (cmdOpcode == `TKF_OP_KEYEN && (cmdParam[6:4] != 3'h0 || cmdParam[3:0] > 4'h8))
			rcNext = `TKF_RC_BAD_PARAM;
		else if (cmdOpcode == `TKF_OP_SLEEP && cmdParam[7])
			rcNext = `TKF_RC_BAD_PARAM;
		else if (cmdOpcode == `TKF_OP_OUTPUTS && (cmdParam[7:5] != 3'h0 || cmdLength != `TKF_OUT_LEN))
			rcNext = `TKF_RC_BAD_PARAM;
	end

	// only a fully accepted command may change state
	wire cmdGood = cmdValid && rcNext == `TKF_RC_OK;

	// ==========================================================
	// command execution
	always @(posedge clk) begin
		if (reset) begin
			fwSeen_q        <= 1'b0;
			resultCode      <= 8'h00;
			resultValid     <= 1'b0;
			keyEnabled      <= 8'hff;
			recalStart      <= 1'b0;
			recalKeys       <= 8'h00;
			outputPinLevels <= 5'h00;
			freeRun_q       <= 1'b0;
			sleepFactor_q   <= 6'h00;
			grpStyle_q      <= 8'h00;
			grpMembers_q    <= 64'h0;
		end else begin
			// every command gets one answer, one cycle later
			resultValid <= cmdValid;
			recalStart  <= 1'b0;
			if (cmdValid)
				resultCode <= rcNext;
			// the init guard opens once the version query is taken
			if (cmdGood && cmdOpcode == `TKF_OP_FWINFO)
				fwSeen_q <= 1'b1;
			if (cmdGood && cmdOpcode == `TKF_OP_KEYEN) begin
				// enable bit picks the requested state for the selection
				if (cmdParam[`TKF_KEYEN_STATE]) begin
					keyEnabled <= keyEnabled | keySelMask(cmdParam[3:0]);
					recalKeys  <= keyEnabled | keySelMask(cmdParam[3:0]);
				end else begin
					keyEnabled <= keyEnabled & ~keySelMask(cmdParam[3:0]);
					recalKeys  <= keyEnabled & ~keySelMask(cmdParam[3:0]);
				end
				// recalibration is asked for even if the set did not change
				recalStart <= 1'b1;
			end
			// pins move only on an accepted command, never mid-frame
			if (cmdGood && cmdOpcode == `TKF_OP_OUTPUTS)
				outputPinLevels <= cmdParam[4:0];
			// sleep byte kept whole; deep sleep is acted on below
			if (cmdGood && cmdOpcode == `TKF_OP_SLEEP) begin
				freeRun_q     <= cmdParam[`TKF_SLEEP_FREERUN];
				sleepFactor_q <= cmdParam[5:0];
			end
			// group table loads without a result code of its own
			if (grpValid) begin
				grpStyle_q   <= grpStyle;
				grpMembers_q <= grpMembers;
			end
		end
	end

	// ==========================================================
	// group lockout: per group, pick winner among touched members
	reg [7:0]         allowed;
	reg [7:0]         grpTouch;
	reg [7:0]         winner;
	reg [LEVEL_W-1:0] best;
	reg [7:0]         ownerNext;
	integer g;
	integer k;
	// disabled keys never count as touched, in or out of a group
	always @* begin
		allowed   = rawTouch & keyEnabled;
		ownerNext = 8'h00;
		grpTouch  = 8'h00;
		winner    = 8'h00;
		best      = {LEVEL_W{1'b0}};
		for (g = 0; g < 8; g = g + 1) begin
			grpTouch = 8'h00;
			for (k = 0; k < 8; k = k + 1)
				grpTouch[k] = grpMembers_q[8*k+g] & rawTouch[k] & keyEnabled[k];
			winner = 8'h00;
			best   = {LEVEL_W{1'b0}};
			if (grpStyle_q[g]) begin
				// strongest signal wins; lowest index breaks ties
				for (k = 7; k >= 0; k = k - 1)
					if (grpTouch[k] && keyLevel[k*LEVEL_W +: LEVEL_W] >= best) begin
						best   = keyLevel[k*LEVEL_W +: LEVEL_W];
						winner = 8'h01 << k;
					end
			end else if (grpTouch != 8'h00) begin
				// first key keeps the group until it lets go; with no
				// holder the lowest touched key takes it
				for (k = 7; k >= 0; k = k - 1)
					if (grpTouch[k])
						winner = 8'h01 << k;
				for (k = 0; k < 8; k = k + 1)
					if (grpTouch[k] && grpMembers_q[8*k+g] && lockOwner_q[k])
						winner = 8'h01 << k;
			end
			// a key in several groups must win in each of them
			for (k = 0; k < 8; k = k + 1)
				if (grpMembers_q[8*k+g] && !winner[k])
					allowed[k] = 1'b0;
		end
		// a key stays owner while touched and still allowed
		ownerNext = allowed;
	end

	// holder state lags one cycle, which decides who pressed first
	always @(posedge clk) begin
		if (reset) begin
			lockOwner_q <= 8'h00;
			touchBitmap <= 8'h00;
		end else begin
			lockOwner_q <= ownerNext;
			touchBitmap <= allowed;
		end
	end

	// ==========================================================
	// touch and fault answers
	// summary ignores enables: a disabled key may still be faulty
	reg [2:0] faultOr;
	integer f;
	always @* begin
		faultOr = 3'h0;
		for (f = 0; f < 8; f = f + 1)
			faultOr = faultOr | faultOf(f[2:0]);
	end

	always @(posedge clk) begin
		if (reset) begin
			summaryFaultByte <= 8'h00;
			keyFaultByte     <= 8'h00;
			keyProbeCode     <= 8'h00;
		end else begin
			// summary bit 7 stays clear; per-key bit 7 is the touch
			summaryFaultByte <= {5'h00, faultOr};
			keyFaultByte     <= {touchBitmap[queryKey], 4'h0, faultOf(queryKey)};
			// probe code priority: calibration, error, filters, state
			if (keyCalibrating[queryKey])
				keyProbeCode <= `TKF_PR_CAL;
			else if (keyMaxCount[queryKey] || keyMinCount[queryKey])
				keyProbeCode <= `TKF_PR_ERROR;
			else if (keyFilterPos[queryKey])
				keyProbeCode <= `TKF_PR_POSRECAL;
			else if (keyFilterTouch[queryKey])
				keyProbeCode <= `TKF_PR_TCONFIRM;
			else if (keyFilterRelease[queryKey])
				keyProbeCode <= `TKF_PR_RCONFIRM;
			else if (touchBitmap[queryKey])
				keyProbeCode <= `TKF_PR_TOUCHED;
			else
				keyProbeCode <= `TKF_PR_RELEASED;
		end
	end

	// ==========================================================
	// low power control
	wire lpFactor = sleepFactor_q >= `TKF_SF_MIN_LP && sleepFactor_q <= `TKF_SF_MAX_LP;
	// detect taken after lockout, so blocked keys do not keep it awake
	wire detecting = touchBitmap != 8'h00;
	wire lpWanted = lpFactor && !(freeRun_q && detecting);

	// deep sleep entered at once; any bus traffic or reset leaves it
	always @(posedge clk) begin
		if (reset) begin
			deepSleep      <= 1'b0;
			lowPowerActive <= 1'b0;
		end else begin
			if (cmdGood && cmdOpcode == `TKF_OP_SLEEP && cmdParam[5:0] == `TKF_SF_DEEP)
				deepSleep <= 1'b1;
			else if (busActivity || addrMatch)
				deepSleep <= 1'b0;
			// traffic holds the block awake for as long as it lasts
			if (busActivity || addrMatch)
				lowPowerActive <= 1'b0;
			else
				lowPowerActive <= lpWanted;
		end
	end

	// interval timer: factor steps of the 20 ms base
	// counter runs only while asleep, so every interval starts whole
	always @(posedge clk) begin
		if (reset) begin
			stepCnt_q <= 32'h0;
			stepNum_q <= 5'h00;
			sleepTick <= 1'b0;
		end else begin
			sleepTick <= 1'b0;
			if (!lowPowerActive) begin
				stepCnt_q <= 32'h0;
				stepNum_q <= 5'h00;
			end else if (stepCnt_q == STEP_CYC - 32'h1) begin
				stepCnt_q <= 32'h0;
				if (stepNum_q == sleepFactor_q[4:0] - 5'h01) begin
					stepNum_q <= 5'h00;
					sleepTick <= 1'b1;
				end else
					stepNum_q <= stepNum_q + 5'h01;
			end else
				stepCnt_q <= stepCnt_q + 32'h1;
		end
	end

	// while asleep the address is not acknowledged; the host retries
	// kept combinational so the refusal lands in the acknowledge slot
	assign addrAck = addrMatch && !lowPowerActive && !deepSleep;

endmodule // tkf_cmd_fields

// ===== design/tkf_regs.vh
/*
 * constants for the touch key host command field block: result codes,
 * opcodes, field positions, sleep factor bounds and timing.
 * assumes inclusion by the single design file only.
 */
`ifndef TKF_REGS_VH
`define TKF_REGS_VH

// ==========================================================
// result codes
`define TKF_RC_OK          8'h01
`define TKF_RC_BAD_CMD     8'h83
`define TKF_RC_BAD_PARAM   8'h85
`define TKF_RC_PARITY      8'ha1
`define TKF_RC_CHECKSUM    8'ha3
`define TKF_RC_INIT        8'he0

// ==========================================================
// opcodes
`define TKF_OP_SLEEP       8'h92
`define TKF_OP_KEYEN       8'h97
`define TKF_OP_OUTPUTS     8'h08
`define TKF_OP_FWINFO      8'h80
`define TKF_OUT_LEN        8'h01

// ==========================================================
// field positions
`define TKF_TOUCH_BIT      7
`define TKF_KEYEN_STATE    7
`define TKF_SLEEP_FREERUN  6
`define TKF_FAULT_CAL      0
`define TKF_FAULT_MAX      1
`define TKF_FAULT_MIN      2

// ==========================================================
// sleep factor
`define TKF_SF_MIN_LP      6'h01
`define TKF_SF_MAX_LP      6'h19
`define TKF_SF_DEEP        6'h3f
`define TKF_SLEEP_STEP_MS  20
`define TKF_CLK_HZ         10000000

// ==========================================================
// probe codes
`define TKF_PR_CAL         8'h01
`define TKF_PR_RELEASED    8'h02
`define TKF_PR_TOUCHED     8'h04
`define TKF_PR_ERROR       8'h08
`define TKF_PR_POSRECAL    8'h11
`define TKF_PR_TCONFIRM    8'h14
`define TKF_PR_RCONFIRM    8'h24

`endif

// ===== verification/tkf_cmd_fields_properties.sv
/*
 * checker for the command field block: result timing, byte formats, ack gating.
 * assumes it is bound to the block and sees only its ports.
 */
`timescale 1ns/100ps
module tkf_cmd_fields_props #(
	parameter SLEEP_STEP_CYC = 200000,
	parameter LEVEL_W        = 8
) (
	input logic       clk,
	input logic       reset,
	input logic       cmdValid,
	input logic [7:0] cmdOpcode,
	input logic       cmdChecksumOk,
	input logic       cmdParityOk,
	input logic       busActivity,
	input logic       addrMatch,
	input logic [7:0] resultCode,
	input logic       resultValid,
	input logic [7:0] summaryFaultByte,
	input logic [7:0] keyFaultByte,
	input logic [7:0] keyEnabled,
	input logic       recalStart,
	input logic [7:0] recalKeys,
	input logic [4:0] outputPinLevels,
	input logic       lowPowerActive,
	input logic       deepSleep,
	input logic       sleepTick,
	input logic       addrAck
);
	// ==========================================================
	// properties, one clock domain
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_RC_TIMING: assert property (cmdValid |=> resultValid)
		else $error("result missing after command");
	AST_RC_QUIET: assert property (!cmdValid |=> !resultValid)
		else $error("result without command");
	AST_RC_PARITY: assert property (cmdValid && !cmdParityOk |=> resultCode == 8'ha1 && $stable(keyEnabled))
		else $error("parity fault not reported");
	AST_RC_CKSUM: assert property (cmdValid && cmdParityOk && !cmdChecksumOk |=> resultCode == 8'ha3)
		else $error("checksum fault not reported");
	AST_SUM_FMT: assert property (summaryFaultByte[7:3] == 5'h00)
		else $error("summary byte upper bits set");
	AST_KEY_FMT: assert property (keyFaultByte[6:3] == 4'h0)
		else $error("fault byte reserved bits set");
	AST_ADDR_ACK: assert property (addrAck == (addrMatch && !lowPowerActive && !deepSleep))
		else $error("address ack while asleep");
	AST_ADDR_WAKE: assert property (addrMatch |=> !lowPowerActive)
		else $error("address did not wake");
	AST_RECAL: assert property (resultValid && resultCode == 8'h01 && $past(cmdOpcode) == 8'h97
		|-> recalStart && recalKeys == keyEnabled) else $error("no recalibration after enable change");
	AST_OUT_HOLD: assert property (!cmdValid |=> $stable(outputPinLevels))
		else $error("outputs moved without command");
	AST_DEEP_WAKE: assert property (deepSleep && busActivity && !cmdValid |=> !deepSleep)
		else $error("bus activity did not wake");
	// main scenarios reached
	cover property (deepSleep);
	cover property (lowPowerActive && sleepTick);
	cover property (recalStart);
endmodule // tkf_cmd_fields_props

// ===== verification/tkf_host_model.sv
/*
 * host controller model: hands framed commands to the block, one per strobe.
 * assumes framing and checksum are judged here and passed as flags.
 */
`timescale 1ns/100ps
module tkf_host_model (
	input  logic       clk,
	output logic       cmdValid,
	output logic [7:0] cmdOpcode,
	output logic [7:0] cmdLength,
	output logic [7:0] cmdParam,
	output logic       cmdChecksumOk,
	output logic       cmdParityOk,
	output logic       cmdKnown
);
	// idle bus at time zero
	initial begin
		cmdValid = 1'b0;
		{cmdOpcode, cmdLength, cmdParam} = 24'h000000;
		{cmdKnown, cmdParityOk, cmdChecksumOk} = 3'h7;
	end
	// one command; flags are known, parity, checksum; param scrambled after
	task send(input logic [7:0] op, len, par, input logic [2:0] flg);
		@(posedge clk);
		{cmdOpcode, cmdLength, cmdParam} <= {op, len, par};
		{cmdKnown, cmdParityOk, cmdChecksumOk} <= flg;
		cmdValid <= 1'b1;
		@(posedge clk);
		cmdValid <= 1'b0;
		cmdParam <= ~par;
	endtask
endmodule // tkf_host_model

// ===== verification/touch_key_host_cmd_fields_tb.sv
/*
 * bench for the command field block: command table, faults, lockout, sleep.
 * assumes the host model and the checker are compiled alongside.
 */
`timescale 1ns/100ps
module touch_key_host_cmd_fields_tb;
	localparam STEP = 4;
	logic        clk, reset, grpValid, busActivity, addrMatch;
	logic [7:0]  grpStyle, rawTouch, keyCalibrating, keyMaxCount, keyMinCount;
	logic [7:0]  keyFilterPos, keyFilterTouch, keyFilterRelease;
	logic [63:0] grpMembers, keyLevel;
	logic [2:0]  queryKey;
	logic        cmdValid, cmdChecksumOk, cmdParityOk, cmdKnown;
	logic [7:0]  cmdOpcode, cmdLength, cmdParam;
	logic [7:0]  resultCode, touchBitmap, summaryFaultByte, keyFaultByte, keyProbeCode, keyEnabled, recalKeys;
	logic        resultValid, recalStart, lowPowerActive, deepSleep, sleepTick, addrAck;
	logic [4:0]  outputPinLevels;
	int          n_errors, check_count, n;
	// op len par flags rc, then expected enables and outputs
	logic [55:0] rows[16] = '{56'h80000007_01ff00, 56'h97000507_01ef00, 56'h97000907_85ef00,
		56'h97001507_85ef00, 56'h97008507_01ff00, 56'h97000007_010000, 56'h97008007_01ff00,
		56'h08011507_01ff15, 56'h55000003_83ff15, 56'h08010a05_a1ff15, 56'h08010a06_a3ff15,
		56'h08010a04_a1ff15, 56'h08020a07_85ff15, 56'h08012a07_85ff15, 56'h92008007_85ff15,
		56'h08010a07_01ff0a};
	logic [7:0]  pc[8] = '{8'h01, 8'h08, 8'h11, 8'h14, 8'h24, 8'h04, 8'h02, 8'h08};
	logic [7:0]  fb[8] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h04};

	// ==========================================================
	// design, host and clock
	tkf_cmd_fields #(.SLEEP_STEP_CYC(STEP)) u_dut (.*);
	tkf_host_model u_host (.*);
	always #50 clk = ~clk;

	// ==========================================================
	// helpers
	task chk(input logic [7:0] seen, exp, input string nm);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task look(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// send one row and look at the answer in its single valid cycle
	task cmd(input logic [55:0] r);
		u_host.send(r[55:48], r[47:40], r[39:32], r[26:24]);
		#1;
		chk(8'(resultValid), 8'h01, "resultValid");
		chk(resultCode, r[23:16], "resultCode");
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard; the whole run is far shorter
	initial begin
		repeat (4000) @(posedge clk);
		n_errors++;
		complete_run;
	end

	// ==========================================================
	// main sequence
	initial begin
		{clk, reset, grpValid, busActivity, addrMatch, queryKey} = 8'h40;
		{grpStyle, rawTouch, keyCalibrating, keyMaxCount, keyMinCount} = 40'h0;
		{keyFilterPos, keyFilterTouch, keyFilterRelease, grpMembers, keyLevel} = 152'h0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		look(1);
		chk(keyEnabled, 8'hff, "keyEnabled");
		chk({3'h0, outputPinLevels}, 8'h00, "outputPinLevels");
		cmd(56'h92000507_e00000);
		$display("test reset and init done");
		foreach (rows[i]) begin
			cmd(rows[i]);
			chk(keyEnabled, rows[i][15:8], "keyEnabled");
			chk({3'h0, outputPinLevels}, rows[i][7:0], "outputPinLevels");
		end
		$display("test command table done");
		// one condition on seven of the eight keys, so every probe code appears
		@(posedge clk);
		{keyCalibrating, keyMaxCount, keyFilterPos, keyFilterTouch} <= 32'h01020408;
		{keyFilterRelease, rawTouch, keyMinCount} <= 24'h102080;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			queryKey <= i[2:0];
			look(3);
			chk(keyProbeCode, pc[i], "keyProbeCode");
			chk(keyFaultByte, fb[i], "keyFaultByte");
		end
		chk(touchBitmap, 8'h20, "touchBitmap");
		chk(summaryFaultByte, 8'h07, "summaryFaultByte");
		$display("test faults and probes done");
		// keys 1 and 2 share group 1; key 2 pressed first must hold
		@(posedge clk);
		{keyCalibrating, keyMaxCount, keyFilterPos, keyFilterTouch} <= 32'h0;
		{keyFilterRelease, rawTouch, keyMinCount} <= 24'h0;
		{grpValid, grpStyle, grpMembers} <= {1'b1, 8'h00, 64'h0101};
		@(posedge clk);
		grpValid <= 1'b0;
		rawTouch <= 8'h02;
		repeat (3) @(posedge clk);
		rawTouch <= 8'h03;
		look(3);
		chk(touchBitmap, 8'h02, "touchBitmap");
		@(posedge clk);
		{grpValid, grpStyle, keyLevel} <= {1'b1, 8'h01, 64'h10ff};
		@(posedge clk);
		grpValid <= 1'b0;
		look(3);
		chk(touchBitmap, 8'h01, "touchBitmap");
		$display("test lockout done");
		// sleep interval of two steps: four ticks in 40 cycles
		@(posedge clk);
		rawTouch <= 8'h00;
		cmd(56'h92000207_010000);
		n = 0;
		repeat (40) begin
			look(1);
			n += sleepTick;
		end
		chk(n[7:0], 8'h04, "sleepTick");
		// an address seen asleep is refused at once but wakes the block
		@(posedge clk);
		addrMatch <= 1'b1;
		#1;
		chk(8'(addrAck), 8'h00, "addrAck");
		look(1);
		chk(8'(lowPowerActive), 8'h00, "lowPowerActive");
		chk(8'(addrAck), 8'h01, "addrAck");
		@(posedge clk);
		addrMatch <= 1'b0;
		cmd(56'h92004207_010000);
		@(posedge clk);
		rawTouch <= 8'h01;
		look(3);
		chk(8'(lowPowerActive), 8'h00, "lowPowerActive");
		@(posedge clk);
		rawTouch <= 8'h00;
		look(3);
		chk(8'(lowPowerActive), 8'h01, "lowPowerActive");
		cmd(56'h92001a07_010000);
		look(1);
		chk(8'(lowPowerActive), 8'h00, "lowPowerActive");
		cmd(56'h92003f07_010000);
		chk(8'(deepSleep), 8'h01, "deepSleep");
		@(posedge clk);
		busActivity <= 1'b1;
		@(posedge clk);
		busActivity <= 1'b0;
		look(1);
		chk(8'(deepSleep), 8'h00, "deepSleep");
		cmd(56'h92000507_010000);
		$display("test sleep done");
		// reset in mid-run: settings back to defaults, init guard closed again
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		look(1);
		chk(keyEnabled, 8'hff, "keyEnabled");
		chk({3'h0, outputPinLevels}, 8'h00, "outputPinLevels");
		chk(8'(lowPowerActive), 8'h00, "lowPowerActive");
		cmd(56'h08010a07_e00000);
		chk({3'h0, outputPinLevels}, 8'h00, "outputPinLevels");
		$display("test mid-run reset done");
		complete_run;
	end
endmodule // touch_key_host_cmd_fields_tb

bind tkf_cmd_fields tkf_cmd_fields_props #(.SLEEP_STEP_CYC(SLEEP_STEP_CYC), .LEVEL_W(LEVEL_W)) u_props (.*);
